// ===== include/sfs_defs.vh
// Purpose: constants for the switching fault and mode supervisor
// Assumes: 250 MHz system clock, 4 ns period
// Notes:   times are kept in their own unit, cycle counts derived from them
`ifndef SFS_DEFS_VH
`define SFS_DEFS_VH

`define SFS_CLK_MHZ          250
`define SFS_OLP_DELAY_MS     40
`define SFS_SOFTSTART_MS     10
`define SFS_RESTART_MS       650
`define SFS_OLP_CYCLES       (`SFS_OLP_DELAY_MS * 1000 * `SFS_CLK_MHZ)
`define SFS_SS_CYCLES        (`SFS_SOFTSTART_MS * 1000 * `SFS_CLK_MHZ)
`define SFS_RESTART_CYCLES   (`SFS_RESTART_MS * 1000 * `SFS_CLK_MHZ)
`define SFS_AOC_LIMIT        2'h3
`define SFS_CAUSE_OLP        0
`define SFS_CAUSE_AOC        1
`define SFS_CAUSE_OVP        2
`define SFS_CAUSE_FBO        3
`define SFS_CAUSE_TSD        4

`endif

// ===== rtl/sfs_supervisor.v
// Purpose: fault supervision, soft-start, burst and green mode control
// Assumes: comparator and lockout inputs are asynchronous levels
// Notes:   all inputs pass a two-stage synchroniser; outputs are flops
//
// Behaviour
// - Comp level at overload threshold starts fixed 40 ms overload delay.
// - Overload still present when delay ends stops switching; shorter transients ignored.
// - Abnormal current compare only after blanking interval in each cycle.
// - Two-bit counter of abnormal cycles; fourth one sets shutdown, stops switching.
// - Over-temperature stops switching; restart only after low-temperature indication.
// - Supply over-voltage immediately stops switching and records fault.
// - Feedback below open-loop threshold stops switching and records fault.
// - Feedback open protection masked for whole soft-start interval.
// - Soft-start of 10 ms after switching starts, current limit rising.
// - Pulse width limit steps up from small value during soft-start.
// - Comp below low burst threshold enters burst, switching stops.
// - In burst, comp above high burst threshold resumes switching.
// - Green mode lowers frequency as comp level falls.
// - At green floor hold frequency in narrow reduced band until burst.
// - Random frequency fluctuation stays active in burst mode.
// - Any fault starts restart timer; regulator kept until 650 ms, then off.
// - Supply at stop level clears protection, re-enables startup source.
// - Supply at start level resumes switching beginning with soft-start.
// - Current comparator ignored for blanking interval after each turn-on.
`timescale 1ns/1ps
`include "sfs_defs.vh"

module sfs_supervisor #(
  parameter OLP_CYCLES     = `SFS_OLP_CYCLES,
  parameter SS_CYCLES      = `SFS_SS_CYCLES,
  parameter RESTART_CYCLES = `SFS_RESTART_CYCLES,
  parameter LEB_CYCLES     = 64,
  parameter SS_STEP_BITS   = 3
) (
  input  wire       I_SYS_CLK,
  input  wire       I_RESET_N,
  input  wire       i_cycle_start,
  input  wire       i_comp_overload,
  input  wire       i_comp_below_burst_low,
  input  wire       i_comp_above_burst_high,
  input  wire       i_comp_green_floor,
  input  wire       i_feedback_level_low,
  input  wire       i_supply_over,
  input  wire       i_sense_over_abnormal,
  input  wire       i_temp_high,
  input  wire       i_temp_low,
  input  wire       i_undervoltage_lockout_stop,
  input  wire       i_undervoltage_lockout_start,
  output reg        o_switch_en,
  output reg        o_blank,
  output reg  [2:0] o_soft_start_step,
  output reg        o_green_active,
  output reg        o_green_floor,
  output reg        o_jitter_en,
  output reg        o_burst,
  output reg        o_shutdown_set,
  output reg        o_regulator_en,
  output reg        o_startup_src_en,
  output reg  [4:0] o_fault_cause
);

  localparam NIN = 12;
  // States, one-hot
  localparam ST_OFF   = 5'h01;
  localparam ST_SOFT  = 5'h02;
  localparam ST_RUN   = 5'h04;
  localparam ST_FAULT = 5'h08;
  localparam ST_DRAIN = 5'h10;

  // Switch-on states decode, shared by several outputs
  function is_switching;
    input [4:0] st;
    begin
      is_switching = (st == ST_SOFT) | (st == ST_RUN);
    end
  endfunction

  // Two-flop synchronisers; first stage read only by second
  wire [NIN-1:0] raw = {i_cycle_start, i_comp_overload, i_comp_below_burst_low,
                        i_comp_above_burst_high, i_comp_green_floor, i_feedback_level_low,
                        i_supply_over, i_sense_over_abnormal, i_temp_high, i_temp_low,
                        i_undervoltage_lockout_stop, i_undervoltage_lockout_start};
  reg [NIN-1:0] sync1_reg;
  reg [NIN-1:0] sync2_reg;
  always @(posedge I_SYS_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      sync1_reg <= {NIN{1'b0}};
      sync2_reg <= {NIN{1'b0}};
    end else begin
      sync1_reg <= raw;
      sync2_reg <= sync1_reg;
    end
  end

  wire cyc_s    = sync2_reg[11];
  wire olp_s    = sync2_reg[10];
  wire burl_s   = sync2_reg[9];
  wire burh_s   = sync2_reg[8];
  wire floor_s  = sync2_reg[7];
  wire fbl_s    = sync2_reg[6];
  wire ovp_s    = sync2_reg[5];
  wire aoc_s    = sync2_reg[4];
  wire thi_s    = sync2_reg[3];
  wire tlo_s    = sync2_reg[2];
  wire stop_s   = sync2_reg[1];
  wire start_s  = sync2_reg[0];

  reg        cyc_d_reg;
  wire       cyc_rise = cyc_s & ~cyc_d_reg;
  reg [4:0]  state_reg;
  reg [4:0]  state_next;
  reg [31:0] olp_cnt_reg;
  reg [31:0] ss_cnt_reg;
  reg [31:0] rst_cnt_reg;
  reg [15:0] leb_cnt_reg;
  reg [1:0]  aoc_cnt_reg;
  reg        aoc_seen_reg;
  reg        tsd_hold_reg;
  reg [4:0]  cause_reg;
  reg [4:0]  cause_next;

  wire switching   = is_switching(state_reg);
  wire blank_done  = (leb_cnt_reg == 16'h0000);
  wire olp_expired = olp_s & (olp_cnt_reg >= OLP_CYCLES - 1);
  wire aoc_trip    = cyc_rise & aoc_seen_reg & (aoc_cnt_reg == `SFS_AOC_LIMIT);
  wire fbo_trip    = fbl_s & (state_reg == ST_RUN);

  // Cause vector of new faults this cycle
  always @* begin
    cause_next = 5'h00;
    cause_next[`SFS_CAUSE_OLP] = olp_expired;
    cause_next[`SFS_CAUSE_AOC] = aoc_trip;
    cause_next[`SFS_CAUSE_OVP] = ovp_s;
    cause_next[`SFS_CAUSE_FBO] = fbo_trip;
    cause_next[`SFS_CAUSE_TSD] = thi_s;
  end

  // Main sequence
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_OFF: begin
        if (start_s & ~tsd_hold_reg & ~ovp_s)
          state_next = ST_SOFT;
      end
      ST_SOFT: begin
        if (|cause_next)
          state_next = ST_FAULT;
        else if (ss_cnt_reg >= SS_CYCLES - 1)
          state_next = ST_RUN;
      end
      ST_RUN: begin
        if (|cause_next)
          state_next = ST_FAULT;
      end
      ST_FAULT: begin
        if (rst_cnt_reg >= RESTART_CYCLES - 1)
          state_next = ST_DRAIN;
      end
      ST_DRAIN: begin
        if (stop_s)
          state_next = ST_OFF;
      end
      default: state_next = ST_OFF;
    endcase
  end

  // Timers and counters; a fault forces switching off at once
  always @(posedge I_SYS_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      state_reg    <= ST_OFF;
      cyc_d_reg    <= 1'b0;
      olp_cnt_reg  <= 32'h00000000;
      ss_cnt_reg   <= 32'h00000000;
      rst_cnt_reg  <= 32'h00000000;
      leb_cnt_reg  <= 16'h0000;
      aoc_cnt_reg  <= 2'h0;
      aoc_seen_reg <= 1'b0;
      tsd_hold_reg <= 1'b0;
      cause_reg    <= 5'h00;
    end else begin
      state_reg <= state_next;
      cyc_d_reg <= cyc_s;
      // Overload delay; restarts whenever the level drops
      if (switching & olp_s)
        olp_cnt_reg <= olp_cnt_reg + 32'h00000001;
      else
        olp_cnt_reg <= 32'h00000000;
      if (state_reg == ST_SOFT)
        ss_cnt_reg <= ss_cnt_reg + 32'h00000001;
      else
        ss_cnt_reg <= 32'h00000000;
      if (state_reg == ST_FAULT)
        rst_cnt_reg <= rst_cnt_reg + 32'h00000001;
      else
        rst_cnt_reg <= 32'h00000000;
      // Blanking restarts on every turn-on
      if (cyc_rise & switching)
        leb_cnt_reg <= LEB_CYCLES[15:0];
      else if (!blank_done)
        leb_cnt_reg <= leb_cnt_reg - 16'h0001;
      // Abnormal current count per switching cycle
      if (!switching) begin
        aoc_cnt_reg  <= 2'h0;
        aoc_seen_reg <= 1'b0;
      end else if (cyc_rise) begin
        aoc_seen_reg <= 1'b0;
        if (aoc_seen_reg)
          aoc_cnt_reg <= aoc_cnt_reg + 2'h1;
        else
          aoc_cnt_reg <= 2'h0;
      end else if (blank_done & aoc_s) begin
        aoc_seen_reg <= 1'b1;
      end
      // Thermal hysteresis: held until low indication
      if (thi_s)
        tsd_hold_reg <= 1'b1;
      else if (tlo_s)
        tsd_hold_reg <= 1'b0;
      // Cause sticks until the protection is cleared at stop level
      if (switching & (|cause_next))
        cause_reg <= cause_next;
      else if ((state_reg == ST_DRAIN) & stop_s)
        cause_reg <= 5'h00;
    end
  end

  // Mode outputs; burst latch gives the hysteresis loop
  reg burst_reg;
  always @(posedge I_SYS_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      burst_reg <= 1'b0;
    end else if (state_reg != ST_RUN) begin
      burst_reg <= 1'b0;
    end else if (burl_s) begin
      burst_reg <= 1'b1;
    end else if (burh_s) begin
      burst_reg <= 1'b0;
    end
  end

  // Soft-start step: eight equal slices of the soft-start time
  // Counter top bits never move for real soft-start lengths, so slice explicitly
  localparam STEP_LEN = SS_CYCLES / 8;
  reg [31:0] step_tmr_reg;
  reg [2:0]  step_reg;
  always @(posedge I_SYS_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      step_tmr_reg <= 32'h00000000;
      step_reg     <= 3'h0;
    end else if (state_reg != ST_SOFT) begin
      step_tmr_reg <= 32'h00000000;
      step_reg     <= 3'h0;
    end else if (step_tmr_reg >= STEP_LEN - 1) begin
      // Saturate at full width; RUN forces full width anyway
      step_tmr_reg <= 32'h00000000;
      if (step_reg != 3'h7)
        step_reg <= step_reg + 3'h1;
    end else begin
      step_tmr_reg <= step_tmr_reg + 32'h00000001;
    end
  end

  // Registered outputs
  always @(posedge I_SYS_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      o_switch_en       <= 1'b0;
      o_blank           <= 1'b1;
      o_soft_start_step <= 3'h0;
      o_green_active    <= 1'b0;
      o_green_floor     <= 1'b0;
      o_jitter_en       <= 1'b0;
      o_burst           <= 1'b0;
      o_shutdown_set    <= 1'b0;
      o_regulator_en    <= 1'b0;
      o_startup_src_en  <= 1'b1;
      o_fault_cause     <= 5'h00;
    end else begin
      // Switch off in the same edge a fault is seen
      o_switch_en       <= (state_next == ST_SOFT) |
                           ((state_next == ST_RUN) & ~burst_reg);
      o_blank           <= ~blank_done | ~switching;
      // Pulse width step: explicit soft-start slice, full width in RUN
      o_soft_start_step <= (state_reg == ST_RUN) ? 3'h7 :
                           (state_reg == ST_SOFT) ?
                           step_reg : 3'h0;
      o_green_active    <= (state_reg == ST_RUN);
      o_green_floor     <= (state_reg == ST_RUN) & floor_s & ~burst_reg;
      o_jitter_en       <= is_switching(state_reg);
      // Gate with RUN so burst never outlives a fault by one cycle
      o_burst           <= burst_reg & (state_reg == ST_RUN);
      o_shutdown_set    <= aoc_trip;
      o_regulator_en    <= (state_reg != ST_DRAIN);
      // Next state only, so the source drops on the edge switching starts
      o_startup_src_en  <= (state_next == ST_OFF);
      o_fault_cause     <= cause_reg;
    end
  end

endmodule

// ===== verif/sfs_power_stage.sv
// Purpose: switching cycles and sense comparator for the supervisor
// Assumes: 32-clock cycle, 16 clocks on-time, switch idle when disabled
// Notes:   a turn-on spike is always present to exercise blanking
`timescale 1ns/1ps
module sfs_power_stage (
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_sw_en,
  input  wire logic i_abn,
  output logic      o_cyc,
  output logic      o_sense
);
  logic [4:0] ph_reg;
  logic       abn_reg;
  // Cycle phase; abnormal request taken at each turn-on
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ph_reg <= 5'h00;
      abn_reg <= 1'b0;
      o_cyc <= 1'b0;
      o_sense <= 1'b0;
    end else begin
      ph_reg <= i_sw_en ? ph_reg + 5'h01 : 5'h00;
      if (ph_reg == 5'h00) abn_reg <= i_abn;
      o_cyc <= i_sw_en && (ph_reg < 5'h10);
      // Spike in first clocks must be blanked
      o_sense <= i_sw_en && (ph_reg < 5'h02 || (abn_reg && ph_reg > 5'h09 && ph_reg < 5'h10));
    end
  end
endmodule

// ===== verif/sfs_supervisor_assertions.sv
// Purpose: temporal checks on the supervisor ports
// Assumes: inputs pass a two-stage synchroniser
// Notes:   fault latencies allow sync plus one state edge
`timescale 1ns/1ps
`include "sfs_defs.vh"
module sfs_sup_chk (
  input wire       I_SYS_CLK,
  input wire       I_RESET_N,
  input wire       i_cycle_start,
  input wire       i_supply_over,
  input wire       i_temp_high,
  input wire       o_switch_en,
  input wire       o_blank,
  input wire       o_jitter_en,
  input wire       o_burst,
  input wire       o_shutdown_set,
  input wire       o_regulator_en,
  input wire       o_startup_src_en,
  input wire [4:0] o_fault_cause
);
  default clocking @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RESET_N);
  property p_ovp; i_supply_over [*4] |=> !o_switch_en; endproperty
  a_ovp: assert property (p_ovp) else $error("switch on under over-voltage");
  property p_temp; i_temp_high [*4] |=> !o_switch_en; endproperty
  a_temp: assert property (p_temp) else $error("switch on when hot");
  property p_hold; o_fault_cause != 5'h00 |=> !o_switch_en; endproperty
  a_hold: assert property (p_hold) else $error("switch on with fault held");
  property p_sd; o_shutdown_set |=> !o_shutdown_set && o_fault_cause[`SFS_CAUSE_AOC]; endproperty
  a_sd: assert property (p_sd) else $error("shutdown pulse wrong");
  property p_src; o_switch_en |-> !o_startup_src_en; endproperty
  a_src: assert property (p_src) else $error("startup source on while switching");
  property p_reg; $fell(o_regulator_en) |-> o_fault_cause != 5'h00 && !o_switch_en; endproperty
  a_reg: assert property (p_reg) else $error("regulator off without fault");
  property p_burst; o_burst |-> !o_switch_en && o_jitter_en; endproperty
  a_burst: assert property (p_burst) else $error("burst state wrong");
  property p_blank; $rose(i_cycle_start) |-> ##[1:4] o_blank; endproperty
  a_blank: assert property (p_blank) else $error("no blanking after turn-on");
endmodule
bind sfs_supervisor sfs_sup_chk u_chk (.*);

// ===== verif/testbench.sv
// Purpose: self-checking bench for the fault and mode supervisor
// Assumes: shortened overload, soft-start and restart counts
// Notes:   fault causes are checked from a queue by a monitor
`timescale 1ns/1ps
module testbench;
  reg         clk = 0, rst_n = 0, ovl = 0, bl = 0, bh = 0, gf = 0, fbl = 0;
  reg         sov = 0, th = 0, tl = 0, us = 0, ust = 0, abn = 0;
  wire        cyc, sen, sw, blk, ga, gfl, jit, bur, sd, reg_en, src;
  wire [2:0]  step;
  wire [4:0]  cause;
  reg  [4:0]  last, exp_q[$];
  integer     n_mismatch = 0, checks_done = 0, seed = 32'h9b69, cyc_n = 0, k;
  initial forever #2 clk = ~clk;
  sfs_supervisor #(.OLP_CYCLES(200), .SS_CYCLES(100), .RESTART_CYCLES(300), .LEB_CYCLES(4))
  u_dut (.I_SYS_CLK(clk), .I_RESET_N(rst_n), .i_cycle_start(cyc), .i_comp_overload(ovl),
    .i_comp_below_burst_low(bl), .i_comp_above_burst_high(bh), .i_comp_green_floor(gf),
    .i_feedback_level_low(fbl), .i_supply_over(sov), .i_sense_over_abnormal(sen),
    .i_temp_high(th), .i_temp_low(tl), .i_undervoltage_lockout_stop(us), .i_undervoltage_lockout_start(ust),
    .o_switch_en(sw), .o_blank(blk), .o_soft_start_step(step), .o_green_active(ga),
    .o_green_floor(gfl), .o_jitter_en(jit), .o_burst(bur), .o_shutdown_set(sd),
    .o_regulator_en(reg_en), .o_startup_src_en(src), .o_fault_cause(cause));
  sfs_power_stage u_ps (.i_clk(clk), .i_rst_n(rst_n), .i_sw_en(sw), .i_abn(abn),
    .o_cyc(cyc), .o_sense(sen));
  task chk(input [4:0] e, input [4:0] s, input string nm);
    checks_done++;
    if (e !== s) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task report_and_stop;
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Monitor: each new fault cause against oldest note
  always @(negedge clk) begin
    if (cause !== last && cause !== 5'h00) chk(exp_q.size() ? exp_q.pop_front() : 5'h1F, cause,
      "cause");
    last <= cause;
  end
  // Hang guard
  always @(posedge clk) begin
    cyc_n++;
    if (cyc_n == 60000) begin
      n_mismatch++;
      report_and_stop;
    end
  end
  // Start from lockout, run past soft-start
  task start;
    us = 0;
    ust = 1;
    wait (sw === 1'b1);
    @(negedge clk);
    ust = 0;
    repeat (110) @(negedge clk);
  endtask
  // Expect a fault, then walk the auto-restart
  task flt(input [4:0] c);
    exp_q.push_back(c);
    wait (cause !== 5'h00);
    @(negedge clk);
    {ovl, sov, fbl, abn, th} = 5'h00;
    chk(reg_en, 5'h01, "reg_kept");
    k = 0;
    while (reg_en !== 1'b0) begin
      @(negedge clk);
      k++;
    end
    chk(k > 280, 5'h01, "restart");
    us = 1;
    wait (cause === 5'h00);
    @(negedge clk);
    chk(src, 5'h01, "src");
    us = 0;
  endtask
  initial begin
    repeat (12) @(negedge clk);
    rst_n = 1;
    @(negedge clk);
    start;
    chk(step, 5'h07, "step");
    ovl = 1;
    repeat (150) @(negedge clk);
    ovl = 0;
    repeat (5) @(negedge clk);
    chk(cause, 5'h00, "transient");
    ovl = 1;
    repeat (150) @(negedge clk);
    chk(cause, 5'h00, "olp_delay");
    flt(5'h01);
    start;
    sov = 1;
    flt(5'h04);
    fbl = 1;
    ust = 1;
    wait (sw === 1'b1);
    @(negedge clk);
    ust = 0;
    repeat (60) @(negedge clk);
    chk(cause, 5'h00, "fb_soft");
    flt(5'h08);
    start;
    th = 1;
    flt(5'h10);
    ust = 1;
    repeat (50) @(negedge clk);
    chk(sw, 5'h00, "hot_start");
    tl = 1;
    wait (sw === 1'b1);
    @(negedge clk);
    {ust, tl} = 2'h0;
    repeat (110) @(negedge clk);
    bl = 1;
    repeat (6) @(negedge clk);
    chk({bur, sw, jit}, 5'h05, "burst");
    bl = 0;
    bh = 1;
    repeat (6) @(negedge clk);
    chk(sw, 5'h01, "resume");
    bh = 0;
    gf = 1;
    repeat (6) @(negedge clk);
    chk({ga, gfl}, 5'h03, "green");
    gf = 0;
    k = {$random(seed)} % 4;
    abn = 1;
    repeat (k) begin
      @(negedge cyc);
      @(negedge clk);
    end
    abn = 0;
    repeat (2) @(negedge cyc);
    chk(cause, 5'h00, "clean");
    abn = 1;
    flt(5'h02);
    report_and_stop;
  end
endmodule
